// ===== ceh_map.svh
// Object indices, error codes, abort codes and indicator timing for the error block
`ifndef CEH_MAP_SVH
`define CEH_MAP_SVH

`define CEH_IDX_SUMMARY 16'h1001
`define CEH_IDX_HISTORY 16'h1003
`define CEH_SUB_COUNT 8'h00
`define CEH_SUB_FIRST 8'h01
`define CEH_HIST_MAX 8'hfe
`define CEH_COUNT_RESET 8'h00
`define CEH_SUMMARY_RESET 8'h00

`define CEH_ABORT_NONE 32'h0000_0000
`define CEH_ABORT_PARAM 32'h0609_0030
`define CEH_ABORT_RO 32'h0601_0002
`define CEH_ABORT_NOOBJ 32'h0602_0000
`define CEH_ABORT_NOSUB 32'h0609_0011

`define CEH_EC_NONE 16'h0000
`define CEH_EC_OVERRUN 16'h8110
`define CEH_EC_PASSIVE 16'h8120
`define CEH_EC_GUARD 16'h8130
`define CEH_EC_BUSOFF_REC 16'h8140
`define CEH_EC_BUSOFF 16'h8141
`define CEH_EC_PDO_LEN 16'h8210
`define CEH_EC_TEMP 16'h4210
`define CEH_EC_MOTION 16'hff01

`define CEH_AI_NONE 16'h0000
`define CEH_AI_OVERTEMP 16'h0008
`define CEH_AI_TEMP_WARN 16'h0016
`define CEH_AI_IDLE_MOVE 16'h0001
`define CEH_AI_IDLE_MIN 4'h2
`define CEH_AI_IDLE_MAX 4'h8
`define CEH_AI_UNDERSHOOT 16'h0009

`define CEH_SB_GENERIC 0
`define CEH_SB_CURRENT 1
`define CEH_SB_VOLTAGE 2
`define CEH_SB_TEMP 3
`define CEH_SB_COMM 4
`define CEH_SB_PROFILE 5
`define CEH_SB_RSVD 6
`define CEH_SB_MANUF 7

`define CEH_FLASH_MS 200
`define CEH_CLK_KHZ 10000
`define CEH_TRAILER_PH 5

`endif

// ===== ceh_pkg.sv
// Types shared by the error block and its status indicator
`default_nettype none
package ceh_pkg;
	localparam int CEH_NUM_EVT = 11;

	typedef enum logic [3:0] {
		ev_overrun = 4'h0,
		ev_passive = 4'h1,
		ev_guard = 4'h2,
		ev_busoff_rec = 4'h3,
		ev_busoff = 4'h4,
		ev_pdo_len = 4'h5,
		ev_overtemp = 4'h6,
		ev_temp_warn = 4'h7,
		ev_idle_move = 4'h8,
		ev_should_idle = 4'h9,
		ev_undershoot = 4'ha
	} ceh_evt_t;

	typedef enum logic [1:0] {
		nmt_stopped = 2'h0,
		nmt_preop = 2'h1,
		nmt_oper = 2'h2,
		nmt_init = 2'h3
	} ceh_nmt_t;

	typedef enum logic [2:0] {
		lm_off = 3'h0,
		lm_red_on = 3'h1,
		lm_red_3 = 3'h2,
		lm_red_2 = 3'h3,
		lm_red_1 = 3'h4,
		lm_grn_on = 3'h5,
		lm_grn_blink = 3'h6,
		lm_grn_1 = 3'h7
	} ceh_led_mode_t;
endpackage
`default_nettype wire

// ===== ceh_led_if.sv
// Conditions into the network status indicator and its two lamp drives
`timescale 1ns/1ps
`default_nettype none
interface ceh_led_if;
	import ceh_pkg::*;
	logic warn;
	logic guard;
	logic sync_to;
	logic busoff;
	ceh_nmt_t nmt;
	logic red;
	logic green;
	modport src (output warn, output guard, output sync_to, output busoff, output nmt,
		input red, input green);
	modport led (input warn, input guard, input sync_to, input busoff, input nmt,
		output red, output green);
endinterface
`default_nettype wire

// ===== ceh_led_indicator.sv
// Network status indicator: flash patterns for red errors and green NMT state
`timescale 1ns/1ps
`default_nettype none
`include "ceh_map.svh"
module ceh_led_indicator #(
	parameter int PHASE_CYC = `CEH_FLASH_MS * `CEH_CLK_KHZ
) (
	input wire logic mclk,
	input wire logic rst,
	ceh_led_if.led lif
);
	import ceh_pkg::*;

	ceh_led_mode_t mode;
	ceh_led_mode_t mode_r;
	logic [31:0] div_r;
	logic phase_en;
	logic [3:0] ph_r;
	logic [3:0] nflash;
	logic [3:0] plen;
	logic lit;

	// Red over green; bus-off first, then SYNC, guard, warning
	always_comb begin
		if (lif.busoff)
			mode = lm_red_on;
		else if (lif.sync_to)
			mode = lm_red_3;
		else if (lif.guard)
			mode = lm_red_2;
		else if (lif.warn)
			mode = lm_red_1;
		else if (lif.nmt == nmt_oper)
			mode = lm_grn_on;
		else if (lif.nmt == nmt_preop)
			mode = lm_grn_blink;
		else if (lif.nmt == nmt_stopped)
			mode = lm_grn_1;
		else
			mode = lm_off;
	end

	always_comb begin
		unique case (mode_r)
			lm_red_3: nflash = 4'h3;
			lm_red_2: nflash = 4'h2;
			lm_red_1, lm_grn_1: nflash = 4'h1;
			lm_off, lm_red_on, lm_grn_on, lm_grn_blink: nflash = 4'h0;
		endcase
		// Flashes, gaps between them, then the long dark trailer
		plen = 4'((nflash << 1) + 4'(`CEH_TRAILER_PH) - 4'h2);
		lit = (ph_r < 4'((nflash << 1) - 4'h1)) && !ph_r[0];
	end

	assign phase_en = (div_r == 32'(PHASE_CYC - 1));

	always_ff @(posedge mclk) begin
		if (rst || mode != mode_r)
			div_r <= 32'h0;
		else if (phase_en)
			div_r <= 32'h0;
		else
			div_r <= div_r + 32'h1;
	end

	// Pattern restarts whenever the shown condition changes
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_r <= lm_off;
			ph_r <= 4'h0;
		end else if (mode != mode_r) begin
			mode_r <= mode;
			ph_r <= 4'h0;
		end else if (phase_en) begin
			if (mode_r == lm_grn_blink || ph_r >= plen)
				ph_r <= (mode_r == lm_grn_blink) ? {3'h0, ~ph_r[0]} : 4'h0;
			else
				ph_r <= ph_r + 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lif.red <= 1'b0;
			lif.green <= 1'b0;
		end else begin
			unique case (mode_r)
				lm_red_on: begin
					lif.red <= 1'b1;
					lif.green <= 1'b0;
				end
				lm_red_1, lm_red_2, lm_red_3: begin
					lif.red <= lit;
					lif.green <= 1'b0;
				end
				lm_grn_on: begin
					lif.red <= 1'b0;
					lif.green <= 1'b1;
				end
				lm_grn_blink: begin
					lif.red <= 1'b0;
					lif.green <= ~ph_r[0];
				end
				lm_grn_1: begin
					lif.red <= 1'b0;
					lif.green <= lit;
				end
				lm_off: begin
					lif.red <= 1'b0;
					lif.green <= 1'b0;
				end
			endcase
		end
	end
endmodule // ceh_led_indicator
`default_nettype wire

// ===== ceh_error_block.sv
// Error summary byte, error history, emergency launch and status indicator
//
// Behaviour
// - Keep a read-only eight-bit error summary byte fed by internal error conditions.
// - Summary bits: 0 generic, 1 current, 2 voltage, 3 temp, 4 comm, 5 profile, 7 maker.
// - Every emergency message carries the summary byte.
// - Only errors already sent as emergency messages go into the history.
// - History count at sub-index zero is read/write, 0 to 254, resets to zero.
// - A new error lands in entry one; older entries move one place down.
// - Writing zero to the count empties the whole history.
// - Writing nonzero to the count is refused with abort 0609 0030h.
// - Entry word: error code in low sixteen bits, extra information in high sixteen.
// - Provide the count entry and at least one read-only entry at sub-index one.
// - Object access failures answer with an abort, not an emergency message.
// - Communication error codes 8110h to 8210h, extra information zero.
// - Temperature code 4210h, extra 8h error, 16h pending warning.
// - Motion code FF01h, extra 1h idle in move, 2h-8h should idle, 9h undershoot.
// - Single red flash when a CAN error counter reaches its warning level.
// - Double red flash after a guard or heartbeat consumer event.
// - Triple red flash when SYNC does not arrive within its timeout.
// - Solid red while the CAN controller is bus-off.
// - Green single flash stopped, blinking pre-operational, solid operational; the code keeps green dark while any red condition is active.
`timescale 1ns/1ps
`default_nettype none
`include "ceh_map.svh"
module ceh_error_block #(
	parameter int HIST_DEPTH = 4,
	parameter int PHASE_CYC = `CEH_FLASH_MS * `CEH_CLK_KHZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic od_req,
	input wire logic od_wr,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic [31:0] od_wdata,
	output logic od_ack,
	output logic [31:0] od_rdata,
	output logic od_abort,
	output logic [31:0] od_abort_code,
	input wire logic [ceh_pkg::CEH_NUM_EVT-1:0] evt_pulse,
	input wire logic [3:0] idle_info,
	input wire logic [7:0] err_cond,
	output logic emcy_valid,
	input wire logic emcy_ready,
	output logic [31:0] emcy_word,
	output logic [7:0] emcy_summary,
	input wire logic can_warn,
	input wire logic guard_evt,
	input wire logic sync_timeout,
	input wire logic can_busoff,
	input wire ceh_pkg::ceh_nmt_t nmt_state,
	output logic led_red,
	output logic led_green
);
	import ceh_pkg::*;

	localparam logic [7:0] CNT_MAX = 8'(HIST_DEPTH);

	logic [7:0] summary_nxt;
	logic [7:0] summary_r;

	// Event queue and emergency launch
	logic [CEH_NUM_EVT-1:0] pend_r;
	logic [CEH_NUM_EVT-1:0] pend_clr;
	logic [3:0] pick;
	logic [3:0] idle_r;
	logic launch;
	logic rec;
	logic [31:0] rec_word;

	// History store; element g answers sub-index g+1
	logic [31:0] hist_r [HIST_DEPTH];
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic hist_clr;

	// Reply terms for the object port
	logic [31:0] rd_nxt;
	logic [31:0] abort_nxt;

	// Entry word for each event kind; code low, extra information high
	function automatic logic [31:0] evt_word(input logic [3:0] k, input logic [3:0] ai);
		logic [15:0] code;
		logic [15:0] info;
		code = `CEH_EC_NONE;
		info = `CEH_AI_NONE;
		case (k)
			ev_overrun: code = `CEH_EC_OVERRUN;
			ev_passive: code = `CEH_EC_PASSIVE;
			ev_guard: code = `CEH_EC_GUARD;
			ev_busoff_rec: code = `CEH_EC_BUSOFF_REC;
			ev_busoff: code = `CEH_EC_BUSOFF;
			ev_pdo_len: code = `CEH_EC_PDO_LEN;
			ev_overtemp: begin
				code = `CEH_EC_TEMP;
				info = `CEH_AI_OVERTEMP;
			end
			ev_temp_warn: begin
				code = `CEH_EC_TEMP;
				info = `CEH_AI_TEMP_WARN;
			end
			ev_idle_move: begin
				code = `CEH_EC_MOTION;
				info = `CEH_AI_IDLE_MOVE;
			end
			ev_should_idle: begin
				code = `CEH_EC_MOTION;
				info = {12'h000, ai};
			end
			ev_undershoot: begin
				code = `CEH_EC_MOTION;
				info = `CEH_AI_UNDERSHOOT;
			end
			default: code = `CEH_EC_NONE;
		endcase
		return {info, code};
	endfunction

	// Count object decode, shared by the clear strobe and the reply
	function automatic logic is_count(input logic [15:0] idx, input logic [7:0] sub);
		return idx == `CEH_IDX_HISTORY && sub == `CEH_SUB_COUNT;
	endfunction

	// Lowest numbered pending event goes out first
	function automatic logic [3:0] first_set(input logic [CEH_NUM_EVT-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = CEH_NUM_EVT - 1; i >= 0; i--) begin
			if (v[i])
				r = 4'(i);
		end
		return r;
	endfunction

	// Summary byte follows live conditions; bit 6 is held low
	always_comb begin
		summary_nxt = err_cond;
		summary_nxt[`CEH_SB_COMM] = err_cond[`CEH_SB_COMM] | can_warn | can_busoff;
		summary_nxt[`CEH_SB_RSVD] = 1'b0;
		summary_nxt[`CEH_SB_GENERIC] = |summary_nxt;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			summary_r <= `CEH_SUMMARY_RESET;
		else
			summary_r <= summary_nxt;
	end

	// Events wait here until launched into the emergency word, once no word is on offer
	assign pick = first_set(pend_r);
	assign launch = !emcy_valid && (pend_r != '0);
	assign rec = emcy_valid && emcy_ready;

	always_comb begin
		pend_clr = '0;
		if (launch)
			pend_clr[pick] = 1'b1;
	end

	// A new pulse in the clearing cycle stays pending
	always_ff @(posedge mclk) begin
		if (rst)
			pend_r <= '0;
		else
			pend_r <= (pend_r & ~pend_clr) | evt_pulse;
	end

	// Extra information outside its legal span is pulled to the low end
	always_ff @(posedge mclk) begin
		if (rst)
			idle_r <= `CEH_AI_IDLE_MIN;
		else if (evt_pulse[ev_should_idle])
			idle_r <= (idle_info < `CEH_AI_IDLE_MIN || idle_info > `CEH_AI_IDLE_MAX) ?
				`CEH_AI_IDLE_MIN : idle_info;
	end

	// Word and summary stay frozen while offered, as the sender may stall
	always_ff @(posedge mclk) begin
		if (rst) begin
			emcy_valid <= 1'b0;
			emcy_word <= 32'h0;
			emcy_summary <= `CEH_SUMMARY_RESET;
		end else if (launch) begin
			emcy_valid <= 1'b1;
			emcy_word <= evt_word(pick, idle_r);
			emcy_summary <= summary_nxt;
		end else if (rec) begin
			emcy_valid <= 1'b0;
		end
	end

	// History is fed only from a sent emergency word
	assign rec_word = emcy_word;
	assign hist_clr = od_req && od_wr && is_count(od_index, od_sub) && od_wdata == 32'h0;

	// A record in the clearing cycle still lands, so the count becomes one
	always_comb begin
		cnt_nxt = hist_clr ? `CEH_COUNT_RESET : cnt_r;
		if (rec && cnt_nxt < CNT_MAX)
			cnt_nxt = cnt_nxt + 8'h1;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			cnt_r <= `CEH_COUNT_RESET;
		else
			cnt_r <= cnt_nxt;
	end

	// Shift on record; a clear in the same cycle keeps only the new word
	generate
		for (genvar g = 0; g < HIST_DEPTH; g++) begin : g_hist
			always_ff @(posedge mclk) begin
				if (rst)
					hist_r[g] <= 32'h0;
				else if (rec) begin
					if (g == 0)
						hist_r[g] <= rec_word;
					else
						hist_r[g] <= hist_clr ? 32'h0 : hist_r[(g == 0) ? 0 : g - 1];
				end else if (hist_clr)
					hist_r[g] <= 32'h0;
			end
		end
	endgenerate

	// Object access: answer one cycle after the request
	always_comb begin
		rd_nxt = 32'h0;
		abort_nxt = `CEH_ABORT_NONE;
		if (od_index == `CEH_IDX_SUMMARY) begin
			if (od_sub != `CEH_SUB_COUNT)
				abort_nxt = `CEH_ABORT_NOSUB;
			else if (od_wr)
				abort_nxt = `CEH_ABORT_RO;
			else
				rd_nxt = {24'h0, summary_r};
		end else if (od_index == `CEH_IDX_HISTORY) begin
			if (is_count(od_index, od_sub)) begin
				if (od_wr && od_wdata != 32'h0)
					abort_nxt = `CEH_ABORT_PARAM;
				else if (!od_wr)
					rd_nxt = {24'h0, cnt_r};
			end else if (od_sub > CNT_MAX) begin
				abort_nxt = `CEH_ABORT_NOSUB;
			end else if (od_wr) begin
				abort_nxt = `CEH_ABORT_RO;
			end else begin
				// Entries above the count read as the last clear left them
				for (int i = 0; i < HIST_DEPTH; i++) begin
					if (od_sub == 8'(i + 1))
						rd_nxt = hist_r[i];
				end
			end
		end else begin
			abort_nxt = `CEH_ABORT_NOOBJ;
		end
	end

	// Read data and abort code hold until the next answer
	always_ff @(posedge mclk) begin
		if (rst) begin
			od_ack <= 1'b0;
			od_rdata <= 32'h0;
			od_abort <= 1'b0;
			od_abort_code <= `CEH_ABORT_NONE;
		end else begin
			od_ack <= od_req;
			if (od_req) begin
				od_rdata <= rd_nxt;
				od_abort <= abort_nxt != `CEH_ABORT_NONE;
				od_abort_code <= abort_nxt;
			end else begin
				od_abort <= 1'b0;
			end
		end
	end

	// Conditions are levels; outside logic holds a guard event until cleared
	ceh_led_if lif ();

	assign lif.warn = can_warn;
	assign lif.guard = guard_evt;
	assign lif.sync_to = sync_timeout;
	assign lif.busoff = can_busoff;
	assign lif.nmt = nmt_state;
	assign led_red = lif.red;
	assign led_green = lif.green;

	// Phase length is a parameter so simulation can shorten it
	ceh_led_indicator #(
		.PHASE_CYC(PHASE_CYC)
	) u_led (
		.mclk(mclk),
		.rst(rst),
		.lif(lif.led)
	);
endmodule // ceh_error_block
`default_nettype wire

// ===== ceh_error_block_assertions.sv
// Concurrent checks on the error block ports
`timescale 1ns/1ps
`default_nettype none
module ceh_chk #(
	parameter int HIST_DEPTH = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic od_req,
	input wire logic od_wr,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic [31:0] od_wdata,
	input wire logic od_ack,
	input wire logic [31:0] od_rdata,
	input wire logic od_abort,
	input wire logic [31:0] od_abort_code,
	input wire logic [ceh_pkg::CEH_NUM_EVT-1:0] evt_pulse,
	input wire logic emcy_valid,
	input wire logic emcy_ready,
	input wire logic [31:0] emcy_word,
	input wire logic can_warn,
	input wire logic guard_evt,
	input wire logic sync_timeout,
	input wire logic can_busoff,
	input wire ceh_pkg::ceh_nmt_t nmt_state,
	input wire logic led_red,
	input wire logic led_green
);
	import ceh_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic on_cnt = od_req && od_index == 16'h1003 && od_sub == 8'h00;
	wire logic rd_sum = od_req && !od_wr && od_index == 16'h1001 && od_sub == 8'h00;
	chk_ack_latency: assert property (od_req |=> od_ack)
		else $error("no answer");
	chk_ack_cause: assert property (od_ack |-> $past(od_req))
		else $error("stray ack");
	chk_count_nonzero: assert property (on_cnt && od_wr && od_wdata != 32'h0
		|=> od_abort && od_abort_code == 32'h0609_0030) else $error("nonzero count write");
	chk_count_clear: assert property ((on_cnt && od_wr && od_wdata == 32'h0) ##2
		(on_cnt && !od_wr) |=> od_rdata <= 32'h1) else $error("history not cleared");
	chk_count_range: assert property (on_cnt && !od_wr |=> od_rdata <= HIST_DEPTH)
		else $error("count too large");
	chk_summary_fmt: assert property (rd_sum |=> !od_abort && od_rdata[31:8] == 24'h0
		&& !od_rdata[6]) else $error("summary format");
	chk_summary_ro: assert property (od_req && od_wr && od_index == 16'h1001 |=> od_abort)
		else $error("summary written");
	chk_emcy_hold: assert property (emcy_valid && !emcy_ready |=> emcy_valid
		&& $stable(emcy_word)) else $error("word dropped");
	chk_emcy_code: assert property (emcy_valid |-> emcy_word[15:0] inside
		{16'h8110, 16'h8120, 16'h8130, 16'h8140, 16'h8141, 16'h8210, 16'h4210, 16'hff01})
		else $error("bad code");
	chk_evt_launch: assert property (|evt_pulse |-> ##[1:60] emcy_valid)
		else $error("event not sent");
	chk_busoff_red: assert property (can_busoff [*4] |-> led_red && !led_green)
		else $error("bus-off lamp");
	chk_oper_green: assert property ((nmt_state == nmt_oper && !can_warn && !guard_evt
		&& !sync_timeout && !can_busoff) [*4] |-> led_green && !led_red)
		else $error("operational lamp");
	cover property (rd_sum);
	cover property (emcy_valid && emcy_ready);
	cover property (on_cnt && od_wr && od_wdata != 32'h0);
endmodule // ceh_chk
bind ceh_error_block ceh_chk #(.HIST_DEPTH(HIST_DEPTH)) u_chk (.mclk, .rst, .od_req, .od_wr,
	.od_index, .od_sub, .od_wdata, .od_ack, .od_rdata, .od_abort, .od_abort_code, .evt_pulse,
	.emcy_valid, .emcy_ready, .emcy_word, .can_warn, .guard_evt, .sync_timeout, .can_busoff,
	.nmt_state, .led_red, .led_green);
`default_nettype wire

// ===== ceh_emcy_sink.sv
// Emergency sender model: takes each word after a set stall
`timescale 1ns/1ps
`default_nettype none
module ceh_emcy_sink (
	input wire logic mclk,
	input wire logic emcy_valid,
	input wire logic [31:0] emcy_word,
	input wire logic [7:0] emcy_summary,
	input wire logic [3:0] stall,
	output logic emcy_ready,
	output logic [31:0] got_word,
	output logic [7:0] got_sum,
	output int n_got
);
	int wait_n = 0;
	int got_n = 0;
	logic rdy_r = 1'b0;
	assign emcy_ready = rdy_r;
	assign n_got = got_n;
	always @(posedge mclk) begin
		if (emcy_valid && rdy_r) begin
			got_word <= emcy_word;
			got_sum <= emcy_summary;
			got_n <= got_n + 1;
		end
	end
	// Ready held until the edge that takes the word
	always @(negedge mclk) begin
		wait_n <= (emcy_valid && !rdy_r) ? wait_n + 1 : 0;
		rdy_r <= emcy_valid && wait_n >= stall;
	end
endmodule // ceh_emcy_sink
`default_nettype wire

// ===== ceh_error_block_tb_top.sv
// Self-checking bench for the error block
`timescale 1ns/1ps
`default_nettype none
module ceh_error_block_tb_top;
	import ceh_pkg::*;
	logic mclk = 0, rst = 1, od_req = 0, od_wr = 0, ab;
	logic [15:0] od_index = 16'h0;
	logic [7:0] od_sub = 8'h0, err_cond = 8'h0, emcy_summary, got_sum;
	logic [31:0] od_wdata = 32'h0, od_rdata, od_abort_code, emcy_word, got_word, rd, cd;
	logic [10:0] evt_pulse = 11'h0;
	logic [3:0] idle_info = 4'h0, stall = 4'h0, lc;
	logic od_ack, od_abort, emcy_valid, emcy_ready, led_red, led_green;
	logic can_warn = 0, guard_evt = 0, sync_timeout = 0, can_busoff = 0;
	ceh_nmt_t nmt_state = nmt_init;
	int n_errors = 0, n_tests = 0, n_got, k, r, nr, ng;
	int ev_i [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 9, 9, 10};
	logic [3:0] ev_x [13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 8, 4'hc, 0};
	logic [31:0] ev_w [13] = '{32'h8110, 32'h8120, 32'h8130, 32'h8140, 32'h8141, 32'h8210,
		32'h0008_4210, 32'h0016_4210, 32'h0001_ff01, 32'h0002_ff01, 32'h0008_ff01,
		32'h0002_ff01, 32'h0009_ff01};
	// Lamp rows: conditions, NMT state, pattern length, lit red and green cycles
	logic [3:0] l_c [8] = '{0, 0, 0, 4'h8, 4'h4, 4'he, 4'hf, 0};
	ceh_nmt_t l_n [8] = '{nmt_oper, nmt_preop, nmt_stopped, nmt_oper, nmt_oper, nmt_oper,
		nmt_preop, nmt_init};
	int l_p [8] = '{24, 8, 24, 24, 32, 40, 24, 24};
	int l_r [8] = '{0, 0, 0, 4, 8, 12, 24, 0};
	int l_g [8] = '{24, 4, 4, 0, 0, 0, 0, 0};
	ceh_error_block #(.HIST_DEPTH(4), .PHASE_CYC(4)) u_dut (.mclk, .rst, .od_req, .od_wr,
		.od_index, .od_sub, .od_wdata, .od_ack, .od_rdata, .od_abort, .od_abort_code,
		.evt_pulse, .idle_info, .err_cond, .emcy_valid, .emcy_ready, .emcy_word,
		.emcy_summary, .can_warn, .guard_evt, .sync_timeout, .can_busoff, .nmt_state,
		.led_red, .led_green);
	ceh_emcy_sink u_sink (.mclk, .emcy_valid, .emcy_word, .emcy_summary, .stall,
		.emcy_ready, .got_word, .got_sum, .n_got);
	initial forever #50 mclk = ~mclk;
	task automatic give_verdict();
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d);
		@(negedge mclk);
		{od_req, od_wr, od_index, od_sub, od_wdata} = {1'b1, w, i, s, d};
		@(negedge mclk);
		od_req = 0;
		chk({31'h0, od_ack}, 32'h1);
		rd = od_rdata;
		ab = od_abort;
		cd = od_abort_code;
	endtask
	task automatic take(input logic [31:0] w);
		k = n_got;
		repeat (60) if (n_got == k) @(negedge mclk);
		if (n_got == k) begin
			n_errors++;
			$display("wrong value at %0t: no emergency word taken", $time);
			give_verdict();
		end
		chk(got_word, w);
	endtask
	task automatic refused(input logic [31:0] c);
		chk({31'h0, ab}, 32'h1);
		chk(cd, c);
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		rst = 0;
		od(0, 16'h1003, 8'h00, 0);
		chk(rd, 32'h0);
		err_cond = 8'h48;
		for (r = 0; r < 13; r++) begin
			stall = 4'(r % 4);
			@(negedge mclk);
			idle_info = ev_x[r];
			evt_pulse = 11'h1 << ev_i[r];
			@(negedge mclk);
			evt_pulse = 11'h0;
			take(ev_w[r]);
			chk({24'h0, got_sum}, 32'h09);
			od(0, 16'h1003, 8'h01, 0);
			chk(rd, ev_w[r]);
		end
		od(0, 16'h1003, 8'h00, 0);
		chk(rd, 32'h4);
		for (r = 1; r < 5; r++) begin
			od(0, 16'h1003, 8'(r), 0);
			chk(rd, ev_w[13 - r]);
		end
		od(0, 16'h1003, 8'h05, 0);
		refused(32'h0609_0011);
		od(1, 16'h1003, 8'h00, 32'h3);
		refused(32'h0609_0030);
		od(1, 16'h1003, 8'h01, 0);
		refused(32'h0601_0002);
		od(0, 16'h1001, 8'h00, 0);
		chk(rd, 32'h09);
		od(1, 16'h1001, 8'h00, 0);
		refused(32'h0601_0002);
		od(0, 16'h1002, 8'h00, 0);
		refused(32'h0602_0000);
		od(1, 16'h1003, 8'h00, 0);
		chk({31'h0, ab}, 32'h0);
		od(0, 16'h1003, 8'h00, 0);
		chk(rd, 32'h0);
		od(0, 16'h1003, 8'h01, 0);
		chk(rd, 32'h0);
		// Overrun pulses again in its clearing cycle; bus-off merges while pending
		stall = 4'h3;
		@(negedge mclk);
		evt_pulse = 11'h011;
		@(negedge mclk);
		evt_pulse = 11'h011;
		@(negedge mclk);
		evt_pulse = 11'h0;
		take(32'h8110);
		take(32'h8110);
		take(32'h8141);
		od(0, 16'h1003, 8'h00, 0);
		chk(rd, 32'h3);
		od(0, 16'h1003, 8'h01, 0);
		chk(rd, 32'h8141);
		od(0, 16'h1003, 8'h02, 0);
		chk(rd, 32'h8110);
		rst = 1;
		repeat (2) @(negedge mclk);
		rst = 0;
		od(0, 16'h1003, 8'h00, 0);
		chk(rd, 32'h0);
		for (r = 0; r < 8; r++) begin
			lc = l_c[r];
			{can_warn, guard_evt, sync_timeout, can_busoff} = lc;
			nmt_state = l_n[r];
			repeat (8) @(negedge mclk);
			nr = 0;
			ng = 0;
			repeat (l_p[r]) begin
				@(negedge mclk);
				nr += int'(led_red === 1'b1);
				ng += int'(led_green === 1'b1);
			end
			chk(32'(nr), 32'(l_r[r]));
			chk(32'(ng), 32'(l_g[r]));
		end
		give_verdict();
	end
endmodule // ceh_error_block_tb_top
`default_nettype wire
